// *** include/backlight_pkg.sv ***
// Register map, field positions, reset values and types of the
// backlight fault, curve, sink group and timeout register bank.
// Assumes a byte-wide register port fed by the serial interface engine.
package backlight_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] MODE_CTRL_ADDR = 8'h01;
    localparam logic [7:0] FAULT_STATUS_ADDR = 8'h02;
    localparam logic [7:0] FAULT_IRQ_ENABLE_ADDR = 8'h03;
    localparam logic [7:0] BACKLIGHT_CONFIG_ADDR = 8'h04;
    localparam logic [7:0] SINK_GROUP_SELECT_ADDR = 8'h05;
    localparam logic [7:0] OFF_DELAY_ADDR = 8'h06;
    localparam logic [7:0] DIM_DELAY_ADDR = 8'h07;

    // ****************************************************************
    // Field positions and implemented-bit masks
    // ****************************************************************
    localparam int MODE_BL_ON_BIT = 0;
    localparam int MODE_DIM_BIT = 4;
    localparam int MODE_ACTIVE_BIT = 5;
    localparam int FLT_SHORT_BIT = 4;
    localparam int FLT_THERMAL_BIT = 3;
    localparam int FLT_OVP_BIT = 2;
    localparam int CFG_FADE_BIT = 0;
    localparam int CFG_CURVE_LSB = 1;
    localparam int CFG_CURVE_MSB = 2;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h31;
    localparam logic [7:0] FAULT_MASK = 8'h1C;
    localparam logic [7:0] CFG_MASK = 8'h07;
    localparam logic [7:0] SINK_MASK = 8'h7F;
    localparam logic [7:0] DELAY_MASK = 8'h7F;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] FAULT_STATUS_RST = 8'h00;
    localparam logic [7:0] FAULT_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] BACKLIGHT_CONFIG_RST = 8'h00;
    localparam logic [7:0] SINK_GROUP_SELECT_RST = 8'h00;
    localparam logic [7:0] OFF_DELAY_RST = 8'h00;
    localparam logic [7:0] DIM_DELAY_RST = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CORE_CLK_KHZ = 25000;
    localparam int TICK_PERIOD_MS = 1000;
    localparam int TICK_CYCLES = CORE_CLK_KHZ * TICK_PERIOD_MS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [6:0] independent;
        logic [6:0] group_on;
    } sink_ctrl_t;

    typedef enum logic [1:0] {
        CURVE_LINEAR = 2'b00,
        CURVE_SQUARE = 2'b01,
        CURVE_CUBIC_A = 2'b10,
        CURVE_CUBIC_B = 2'b11
    } curve_t;

    typedef enum logic [2:0] {
        TO_IDLE = 3'b000,
        TO_WAIT_MAX = 3'b001,
        TO_DIM = 3'b010,
        TO_OFF = 3'b011,
        TO_HOLD = 3'b100
    } timeout_state_t;

endpackage : backlight_pkg

// *** hw/backlight_fault_irq_and_timeouts.sv ***
// Backlight register bank: fault flags and interrupt, curve, sink group
// and the dim and off timeouts.
// Assumes the serial engine gives one-cycle read and write strobes on
// core_clk; fault detectors are asynchronous comparators.
//
// Overview of operation
// - Short flag with enable raises the interrupt
// - Thermal flag with enable raises the interrupt
// - Overvoltage flag with enable raises the interrupt
// - Curve 00 linear, 01 square with linear steps
// - Curve 10 and 11 cubic with nonlinear steps
// - Config bit 0 turns fade bypass on
// - Select bit n-1 makes sink n independent
// - Cleared select bit ties sink to group enable
// - Backlight turns off after the off delay
// - Off count waits for the dim expiry unless the dim code is zero
// - Off code zero disables, else code seconds
// - Dim expiry drops backlight to dim level
// - Dim count starts at maximum current only
// - Dim code zero disables, else code seconds
// - Fault flags clear only on written one
// - Hardware sets the dim bit at expiry
// - Group needs backlight on and active mode
`timescale 1ns/10ps
module backlight_fault_irq_and_timeouts #(
    parameter int unsigned TICK_CYCLES = backlight_pkg::TICK_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire backlight_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic short_detect,
    input wire logic thermal_detect,
    input wire logic ovp_detect,
    input wire logic bl_at_max,
    output logic fault_irq,
    output backlight_pkg::curve_t curve,
    output logic fade_bypass,
    output backlight_pkg::sink_ctrl_t sink,
    output logic backlight_group_en,
    output logic dim_active
);
    import backlight_pkg::*;

    // ****************************************************************
    // Reset release and detector synchronisers
    // ****************************************************************
    logic rst_meta_n_r;
    logic rst_sync_n_r;
    logic [2:0] det_meta_r;
    logic [2:0] det_r;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_n_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_n_r <= 1'b1;
            rst_sync_n_r <= rst_meta_n_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_r)
    begin
        if (!rst_sync_n_r)
        begin
            det_meta_r <= 3'h0;
            det_r <= 3'h0;
        end
        else
        begin
            det_meta_r <= {short_detect, thermal_detect, ovp_detect};
            det_r <= det_meta_r;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] flt_r, flt_nxt;
    logic [7:0] irqen_r, irqen_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] sel_r, sel_nxt;
    logic [7:0] off_r, off_nxt;
    logic [7:0] dim_r, dim_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] det_bits;
    logic [7:0] clr_bits;
    logic off_expire;
    logic dim_expire;

    always_comb
    begin
        det_bits = 8'h00;
        det_bits[FLT_SHORT_BIT] = det_r[2];
        det_bits[FLT_THERMAL_BIT] = det_r[1];
        det_bits[FLT_OVP_BIT] = det_r[0];
        clr_bits = 8'h00;
        mode_nxt = mode_r;
        irqen_nxt = irqen_r;
        cfg_nxt = cfg_r;
        sel_nxt = sel_r;
        off_nxt = off_r;
        dim_nxt = dim_r;
        if (reg_req.wr)
        begin
            // Masks drop writes to reserved bits
            if (reg_req.addr == MODE_CTRL_ADDR)
                mode_nxt = reg_req.wdata & MODE_CTRL_MASK;
            else if (reg_req.addr == FAULT_STATUS_ADDR)
                clr_bits = reg_req.wdata & FAULT_MASK;
            else if (reg_req.addr == FAULT_IRQ_ENABLE_ADDR)
                irqen_nxt = reg_req.wdata & FAULT_MASK;
            else if (reg_req.addr == BACKLIGHT_CONFIG_ADDR)
                cfg_nxt = reg_req.wdata & CFG_MASK;
            else if (reg_req.addr == SINK_GROUP_SELECT_ADDR)
                sel_nxt = reg_req.wdata & SINK_MASK;
            else if (reg_req.addr == OFF_DELAY_ADDR)
                off_nxt = reg_req.wdata & DELAY_MASK;
            else if (reg_req.addr == DIM_DELAY_ADDR)
                dim_nxt = reg_req.wdata & DELAY_MASK;
        end
        // Hardware events win over a host write in the same cycle
        if (off_expire)
        begin
            mode_nxt[MODE_BL_ON_BIT] = 1'b0;
            mode_nxt[MODE_DIM_BIT] = 1'b0;
        end
        if (dim_expire)
            mode_nxt[MODE_DIM_BIT] = 1'b1;
        // Set beats write-one clear; reads never touch flags
        flt_nxt = (flt_r & ~clr_bits) | det_bits;
        rdata_nxt = rdata_r;
        if (reg_req.rd)
        begin
            if (reg_req.addr == MODE_CTRL_ADDR)
                rdata_nxt = mode_r;
            else if (reg_req.addr == FAULT_STATUS_ADDR)
                rdata_nxt = flt_r;
            else if (reg_req.addr == FAULT_IRQ_ENABLE_ADDR)
                rdata_nxt = irqen_r;
            else if (reg_req.addr == BACKLIGHT_CONFIG_ADDR)
                rdata_nxt = cfg_r;
            else if (reg_req.addr == SINK_GROUP_SELECT_ADDR)
                rdata_nxt = sel_r;
            else if (reg_req.addr == OFF_DELAY_ADDR)
                rdata_nxt = off_r;
            else if (reg_req.addr == DIM_DELAY_ADDR)
                rdata_nxt = dim_r;
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_r)
    begin
        if (!rst_sync_n_r)
        begin
            mode_r <= MODE_CTRL_RST;
            flt_r <= FAULT_STATUS_RST;
            irqen_r <= FAULT_IRQ_ENABLE_RST;
            cfg_r <= BACKLIGHT_CONFIG_RST;
            sel_r <= SINK_GROUP_SELECT_RST;
            off_r <= OFF_DELAY_RST;
            dim_r <= DIM_DELAY_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            mode_r <= mode_nxt;
            flt_r <= flt_nxt;
            irqen_r <= irqen_nxt;
            cfg_r <= cfg_nxt;
            sel_r <= sel_nxt;
            off_r <= off_nxt;
            dim_r <= dim_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = rdata_r;
    assign fault_irq = |(flt_r & irqen_r & FAULT_MASK);
    assign curve = curve_t'(cfg_r[CFG_CURVE_MSB:CFG_CURVE_LSB]);
    assign fade_bypass = cfg_r[CFG_FADE_BIT];
    assign backlight_group_en = mode_r[MODE_BL_ON_BIT]
        & mode_r[MODE_ACTIVE_BIT];
    assign sink.independent = sel_r[6:0];
    assign sink.group_on = {7{backlight_group_en}} & ~sel_r[6:0];
    assign dim_active = mode_r[MODE_DIM_BIT];

    // ****************************************************************
    // Timeout sequencer
    // ****************************************************************
    timeout_state_t st_r, st_nxt;
    logic [31:0] presc_r, presc_nxt;
    logic [6:0] sec_r, sec_nxt;
    logic tick;
    logic [7:0] sec_inc;

    // Prescaler restarts with each count, so a second is a full second
    assign tick = ((st_r == TO_DIM) || (st_r == TO_OFF))
        && (presc_r == 32'(TICK_CYCLES - 1));
    assign sec_inc = {1'b0, sec_r} + 8'h01;
    assign dim_expire = (st_r == TO_DIM) && tick
        && (sec_inc == {1'b0, dim_r[6:0]});
    assign off_expire = (st_r == TO_OFF) && tick
        && (sec_inc == {1'b0, off_r[6:0]});

    always_comb
    begin
        st_nxt = st_r;
        sec_nxt = sec_r;
        presc_nxt = tick ? 32'h0 : presc_r + 32'h1;
        if (tick)
            sec_nxt = sec_inc[6:0];
        case (st_r)
            TO_IDLE:
            begin
                st_nxt = TO_WAIT_MAX;
                presc_nxt = 32'h0;
            end
            TO_WAIT_MAX:
            begin
                presc_nxt = 32'h0;
                sec_nxt = 7'h00;
                if (bl_at_max)
                begin
                    if (dim_r[6:0] != 7'h00)
                        st_nxt = TO_DIM;
                    else if (off_r[6:0] != 7'h00)
                        st_nxt = TO_OFF;
                    else
                        st_nxt = TO_HOLD;
                end
            end
            TO_DIM:
            begin
                if ((dim_r[6:0] == 7'h00) || dim_expire)
                begin
                    // Off count begins here, or from TO_WAIT_MAX when the dim code is zero
                    st_nxt = (off_r[6:0] != 7'h00) ? TO_OFF : TO_HOLD;
                    presc_nxt = 32'h0;
                    sec_nxt = 7'h00;
                end
            end
            TO_OFF:
            begin
                if (off_r[6:0] == 7'h00)
                    st_nxt = TO_HOLD;
                else if (off_expire)
                    st_nxt = TO_IDLE;
            end
            default:
            begin
                presc_nxt = 32'h0;
                sec_nxt = 7'h00;
            end
        endcase
        // Losing the group enable abandons any count in progress
        if (!backlight_group_en)
        begin
            st_nxt = TO_IDLE;
            presc_nxt = 32'h0;
            sec_nxt = 7'h00;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_r)
    begin
        if (!rst_sync_n_r)
        begin
            st_r <= TO_IDLE;
            presc_r <= 32'h0;
            sec_r <= 7'h00;
        end
        else
        begin
            st_r <= st_nxt;
            presc_r <= presc_nxt;
            sec_r <= sec_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_n_r);

    sequence s_cfg_write;
        reg_req.wr && (reg_req.addr == BACKLIGHT_CONFIG_ADDR);
    endsequence
    sequence s_short_clear;
        reg_req.wr && (reg_req.addr == FAULT_STATUS_ADDR)
            && reg_req.wdata[FLT_SHORT_BIT] && !det_r[2];
    endsequence
    sequence s_dim_start;
        $rose(st_r == TO_DIM);
    endsequence

    a_short_irq: assert property (flt_r[FLT_SHORT_BIT]
        && irqen_r[FLT_SHORT_BIT] |-> fault_irq)
        else $error("short flag enabled but no interrupt");
    a_short_masked: assert property (det_r[2]
        && !irqen_r[FLT_SHORT_BIT] && !reg_req.wr
        && (((flt_r | det_bits) & irqen_r) == 8'h00)
        |=> flt_r[FLT_SHORT_BIT] && !fault_irq)
        else $error("masked short flag wrong");
    a_thermal_irq: assert property (flt_r[FLT_THERMAL_BIT]
        && irqen_r[FLT_THERMAL_BIT] |-> fault_irq)
        else $error("thermal flag enabled but no interrupt");
    a_ovp_irq: assert property (flt_r[FLT_OVP_BIT]
        && irqen_r[FLT_OVP_BIT] |-> fault_irq)
        else $error("overvoltage flag enabled but no interrupt");
    a_irq_cause: assert property (fault_irq
        |-> (flt_r & irqen_r) != 8'h00)
        else $error("interrupt without enabled flag");
    a_curve_write: assert property (s_cfg_write |=> curve
        == curve_t'($past(reg_req.wdata[CFG_CURVE_MSB:CFG_CURVE_LSB])))
        else $error("curve does not follow config write");
    a_fade_write: assert property (s_cfg_write
        |=> fade_bypass == $past(reg_req.wdata[CFG_FADE_BIT]))
        else $error("fade bypass does not follow write");
    a_sink_split: assert property ((sink.independent
        & sink.group_on) == 7'h00)
        else $error("sink both independent and grouped");
    a_group_gate: assert property (sink.group_on != 7'h00
        |-> mode_r[MODE_BL_ON_BIT] && mode_r[MODE_ACTIVE_BIT])
        else $error("group sink on without enable");
    a_off_expire: assert property (off_expire
        |=> !mode_r[MODE_BL_ON_BIT] ##1 st_r == TO_IDLE)
        else $error("backlight not switched off at expiry");
    a_off_after_dim: assert property ($rose(st_r == TO_OFF)
        && ($past(dim_r[6:0]) != 7'h00) |-> $past(st_r) == TO_DIM)
        else $error("off count started before dim expiry");
    a_dim_code_live: assert property ((st_r == TO_DIM)
        && ($past(st_r) == TO_DIM) |-> $past(dim_r[6:0]) != 7'h00)
        else $error("dim count with zero code");
    a_dim_sets_bit: assert property (dim_expire
        |=> dim_active)
        else $error("dim bit not set at expiry");
    a_dim_needs_max: assert property (s_dim_start
        |-> $past(bl_at_max))
        else $error("dim count started before maximum current");
    a_tick_spacing: assert property (s_dim_start
        |-> !tick [*8])
        else $error("tick too soon after count start");
    a_w1c_clear: assert property (s_short_clear
        |=> !flt_r[FLT_SHORT_BIT])
        else $error("short flag not cleared by written one");
    a_flag_keep: assert property (flt_r[FLT_SHORT_BIT]
        && !(reg_req.wr && (reg_req.addr == FAULT_STATUS_ADDR)
        && reg_req.wdata[FLT_SHORT_BIT]) |=> flt_r[FLT_SHORT_BIT])
        else $error("short flag lost without clear");
    a_reserved_zero: assert property (reg_req.rd
        && (reg_req.addr == BACKLIGHT_CONFIG_ADDR) |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved config bits read nonzero");

endmodule : backlight_fault_irq_and_timeouts

// *** tb/backlight_host_model.sv ***
// Host side of the register port: byte writes and reads on strobes.
// Assumes the bank takes a strobe on the rising core_clk edge.
`timescale 1ns/10ps
module backlight_host_model
(
    input wire logic core_clk,
    output backlight_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    import backlight_pkg::*;
    // Idle cycles before each request beyond the one always left, for slow host behaviour
    int gap = 0;
    initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // Released lines show the inverse, never a stale copy
    task automatic drop;
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask : drop

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        repeat (gap + 1) @(negedge core_clk);
        reg_req.addr = a;
        reg_req.wdata = d;
        reg_req.wr = 1'b1;
        @(negedge core_clk);
        drop();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        repeat (gap + 1) @(negedge core_clk);
        reg_req.addr = a;
        reg_req.rd = 1'b1;
        @(negedge core_clk);
        d = reg_rdata;
        drop();
    endtask : read_reg
endmodule : backlight_host_model

// *** tb/backlight_fault_irq_and_timeouts_tb.sv ***
// Self-checking bench of the backlight register bank.
// Assumes a shortened one-second tick of 16 core_clk cycles.
`timescale 1ns/10ps
module backlight_fault_irq_and_timeouts_tb;
    import backlight_pkg::*;
    localparam int TICK = 16;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic short_detect = 1'b0;
    logic thermal_detect = 1'b0;
    logic ovp_detect = 1'b0;
    logic bl_at_max = 1'b0;
    logic fault_irq;
    curve_t curve;
    logic fade_bypass;
    sink_ctrl_t sink;
    logic backlight_group_en;
    logic dim_active;
    int errors = 0;
    int n_compared = 0;
    logic [7:0] rd;
    int n;

    always #20 core_clk = ~core_clk;

    backlight_fault_irq_and_timeouts #(.TICK_CYCLES(TICK)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .short_detect(short_detect),
        .thermal_detect(thermal_detect), .ovp_detect(ovp_detect),
        .bl_at_max(bl_at_max), .fault_irq(fault_irq), .curve(curve),
        .fade_bypass(fade_bypass), .sink(sink),
        .backlight_group_en(backlight_group_en), .dim_active(dim_active));

    backlight_host_model i_host (.core_clk(core_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata));

    // ****************************************************************
    // Compare and helper tasks
    // ****************************************************************
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h seen %h", what, e, g);
            errors++;
        end
    endtask : chk8

    task automatic chk_cnt(input string what, input int lo, input int hi,
                           input int g);
        n_compared++;
        if (g < lo || g > hi)
        begin
            $display("unexpected %s: expected %0d..%0d seen %0d",
                     what, lo, hi, g);
            errors++;
        end
    endtask : chk_cnt

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.read_reg(a, rd);
        chk8("read data", e, rd);
    endtask : rchk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
    endtask : wr

    // Bounded wait: 0 for dim entry, 1 for group drop
    task automatic measure(input int which, output int cnt);
        cnt = 0;
        do
        begin
            @(negedge core_clk);
            cnt++;
            if (cnt > 200)
            begin
                $display("unexpected wait: expected event seen none");
                errors++;
                tally_and_finish();
            end
        end
        while (which == 0 ? dim_active !== 1'b1
                          : backlight_group_en !== 1'b0);
    endtask : measure

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int a = 0; a < 9; a++)
            rchk(8'(a), 8'h00);
        chk8("irq", 8'h00, {7'h00, fault_irq});
        chk8("group", 8'h00, {7'h00, backlight_group_en});
        $display("test reset done");
    endtask : t_reset

    task automatic t_config;
        for (int c = 0; c < 8; c++)
        begin
            wr(BACKLIGHT_CONFIG_ADDR, 8'(c) | 8'hF8);
            chk8("curve", 8'(c >> 1), {6'h00, curve});
            chk8("fade", 8'(c & 1), {7'h00, fade_bypass});
            rchk(BACKLIGHT_CONFIG_ADDR, 8'(c));
        end
        i_host.gap = 3;
        wr(8'h08, 8'hFF);
        rchk(8'h08, 8'h00);
        i_host.gap = 0;
        $display("test config done");
    endtask : t_config

    task automatic t_sinks;
        wr(SINK_GROUP_SELECT_ADDR, 8'hD5);
        rchk(SINK_GROUP_SELECT_ADDR, 8'h55);
        chk8("indep", 8'h55, {1'b0, sink.independent});
        chk8("grp off", 8'h00, {1'b0, sink.group_on});
        wr(MODE_CTRL_ADDR, 8'h21);
        chk8("grp on", 8'h2A, {1'b0, sink.group_on});
        wr(MODE_CTRL_ADDR, 8'h01);
        chk8("stby", 8'h00, {7'h00, backlight_group_en});
        wr(MODE_CTRL_ADDR, 8'h20);
        chk8("bl off", 8'h00, {1'b0, sink.group_on});
        wr(SINK_GROUP_SELECT_ADDR, 8'h40);
        chk8("sink7", 8'h40, {1'b0, sink.independent});
        $display("test sinks done");
    endtask : t_sinks

    task automatic set_det(input int k, input logic v);
        case (k)
            0: short_detect = v;
            1: thermal_detect = v;
            default: ovp_detect = v;
        endcase
    endtask : set_det

    task automatic t_faults;
        logic [7:0] m;
        for (int k = 0; k < 3; k++)
        begin
            m = 8'h10 >> k;
            wr(FAULT_IRQ_ENABLE_ADDR, ~m);
            set_det(k, 1'b1);
            repeat (4) @(negedge core_clk);
            rchk(FAULT_IRQ_ENABLE_ADDR, ~m & FAULT_MASK);
            rchk(FAULT_STATUS_ADDR, m);
            chk8("irq off", 8'h00, {7'h00, fault_irq});
            wr(FAULT_IRQ_ENABLE_ADDR, m);
            chk8("irq on", 8'h01, {7'h00, fault_irq});
            set_det(k, 1'b0);
            repeat (4) @(negedge core_clk);
            wr(FAULT_STATUS_ADDR, ~m);
            rchk(FAULT_STATUS_ADDR, m);
            wr(FAULT_STATUS_ADDR, m);
            rchk(FAULT_STATUS_ADDR, 8'h00);
            chk8("irq clr", 8'h00, {7'h00, fault_irq});
        end
        rchk(FAULT_IRQ_ENABLE_ADDR, 8'h04);
        $display("test faults done");
    endtask : t_faults

    task automatic t_dim_off;
        wr(DIM_DELAY_ADDR, 8'h81);
        wr(OFF_DELAY_ADDR, 8'h02);
        rchk(DIM_DELAY_ADDR, 8'h01);
        wr(MODE_CTRL_ADDR, 8'h21);
        repeat (3 * TICK) @(negedge core_clk);
        chk8("early dim", 8'h00, {7'h00, dim_active});
        bl_at_max = 1'b1;
        measure(0, n);
        chk_cnt("dim time", TICK, TICK + 4, n);
        chk8("grp dim", 8'h01, {7'h00, backlight_group_en});
        measure(1, n);
        chk_cnt("off time", 2 * TICK - 1, 2 * TICK + 3, n);
        rchk(MODE_CTRL_ADDR, 8'h20);
        $display("test dim off done");
    endtask : t_dim_off

    task automatic t_codes;
        wr(DIM_DELAY_ADDR, 8'h00);
        wr(OFF_DELAY_ADDR, 8'h01);
        wr(MODE_CTRL_ADDR, 8'h21);
        measure(1, n);
        chk_cnt("off only", TICK - 1, TICK + 4, n);
        chk8("no dim", 8'h00, {7'h00, dim_active});
        wr(OFF_DELAY_ADDR, 8'h00);
        wr(MODE_CTRL_ADDR, 8'h21);
        repeat (5 * TICK) @(negedge core_clk);
        chk8("hold", 8'h01, {7'h00, backlight_group_en});
        chk8("hold dim", 8'h00, {7'h00, dim_active});
        $display("test codes done");
    endtask : t_codes

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_config();
        t_sinks();
        t_faults();
        t_dim_off();
        t_codes();
        tally_and_finish();
    end
endmodule : backlight_fault_irq_and_timeouts_tb
